// *** hdl/dcsw_pkg.sv ***
package dcsw_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] DCSW_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] DCSW_ADDR_STATUS = 4'h4;
	localparam logic [3:0] DCSW_ADDR_MODE   = 4'h8;
	localparam logic [3:0] DCSW_ADDR_SEQ    = 4'hc;

	// ------------------------------------------------------------
	// Control word bit positions
	// ------------------------------------------------------------
	localparam int DCSW_CB_RUN   = 0;
	localparam int DCSW_CB_COAST = 1;
	localparam int DCSW_CB_QUICK = 2;
	localparam int DCSW_CB_PERM  = 3;
	localparam int DCSW_CB_CLEAR = 7;

	// ------------------------------------------------------------
	// Status word bit positions
	// ------------------------------------------------------------
	localparam int DCSW_SB_READY  = 0;
	localparam int DCSW_SB_ENERG  = 1;
	localparam int DCSW_SB_OPER   = 2;
	localparam int DCSW_SB_FAULT  = 3;
	localparam int DCSW_SB_COAST  = 4;
	localparam int DCSW_SB_QUICK  = 5;
	localparam int DCSW_SB_INHIB  = 6;
	localparam int DCSW_SB_REMOTE = 9;

	// Mode register bits
	localparam int DCSW_MB_LINK = 0;
	localparam int DCSW_MB_REM  = 1;
	localparam int DCSW_MB_SEL  = 2;

	localparam logic [15:0] DCSW_CTRL_RST = 16'h0000;
	localparam logic [2:0]  DCSW_MODE_RST = 3'h0;
	localparam logic [2:0]  DCSW_STATE_INHIBIT = 3'h1;

	// ------------------------------------------------------------
	// Grouped signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} dcsw_bus_s;

	typedef struct packed {
		logic forward_run_request;
		logic reverse_run_request;
		logic halt_inhibit;
		logic freewheel_off_command;
		logic quick_off_command;
		logic output_permit;
		logic remote_fault_clear;
	} dcsw_seq_in_s;

	typedef struct packed {
		logic       ready_to_energise;
		logic       stack_energised;
		logic       operating;
		logic       fault_latched;
		logic [2:0] state_code;
	} dcsw_seq_out_s;

endpackage : dcsw_pkg

// *** hdl/dcsw_word_reg.sv ***
`timescale 1ns/100ps
module dcsw_word_reg (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Load port
	input  wire logic        load,
	input  wire logic [15:0] din,
	// Stored word
	output logic      [15:0] dout
);
	import dcsw_pkg::*;

	typedef struct packed {
		logic [15:0] word;
	} dcsw_wreg_s;

	dcsw_wreg_s st_r;
	dcsw_wreg_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.word = din;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{word: DCSW_CTRL_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.word;

endmodule : dcsw_word_reg

// *** hdl/dcsw_top.sv ***
`timescale 1ns/100ps
// Contract
// - Link mode takes inputs from control word
// - Only the bus write alters control word
// - Control word readable as diagnostic copy
// - Bit0 drives forward run, reverse/halt false
// - Bit1 drives freewheel release directly
// - Bit2 drives quick halt release directly
// - Bit3 drives output stage permit
// - Bit7 fault clear acts on rising edge
// - Unsupported status bits read zero
// - Status bit0 is ready-to-energise
// - Status bit1 is stack energised
// - Status bit2 is operating flag
// - Status bit3 is fault latched
// - Status bit4 mirrors freewheel release source
// - Status bit5 mirrors quick halt source
// - Status bit6 set only in inhibit state
// - Status bit9 is mode remote bit AND mode select bit
// - Fault exit needs clear rising edge in link mode; local mode passes the clear level through
// - Inhibit state has code one
module dcsw_top (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	// Register port
	input  wire dcsw_pkg::dcsw_bus_s     bus,
	output logic                  [15:0] rdata,
	// Local sequencing inputs
	input  wire dcsw_pkg::dcsw_seq_in_s  local_in,
	// Sequencer side
	input  wire dcsw_pkg::dcsw_seq_out_s seq_out,
	output dcsw_pkg::dcsw_seq_in_s       seq_in
);
	import dcsw_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Local inputs come from pins: two-stage synchroniser
	// ------------------------------------------------------------
	dcsw_seq_in_s loc_s1_r;
	dcsw_seq_in_s loc_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			loc_s1_r <= '0;
			loc_r    <= '0;
		end else begin
			loc_s1_r <= local_in;
			loc_r    <= loc_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Control word store
	// ------------------------------------------------------------
	logic [15:0] ctrl_word;
	logic        ctrl_load;

	// Bus is the only writer; nothing internal feeds the store
	assign ctrl_load = bus.wr && (bus.addr == DCSW_ADDR_CTRL);

	dcsw_word_reg u_ctrl (
		.clk   (clk),
		.rst_n (rst_n_r),
		.load  (ctrl_load),
		.din   (bus.wdata),
		.dout  (ctrl_word)
	);

	// ------------------------------------------------------------
	// Block state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]   mode;
		logic         clr_prev;
		dcsw_seq_in_s seq;
		logic [15:0]  rdata;
	} dcsw_state_s;

	dcsw_state_s st_r;
	dcsw_state_s st_nxt;

	function automatic logic [15:0] status_word(
		input dcsw_seq_out_s so,
		input logic          link,
		input logic          remote_sel,
		input logic          coast,
		input logic          quick
	);
		logic [15:0] w;
		w = 16'h0000;
		w[DCSW_SB_READY]  = so.ready_to_energise;
		w[DCSW_SB_ENERG]  = so.stack_energised;
		w[DCSW_SB_OPER]   = so.operating;
		w[DCSW_SB_FAULT]  = so.fault_latched;
		w[DCSW_SB_COAST]  = coast;
		w[DCSW_SB_QUICK]  = quick;
		// Inhibit state code is fixed at one
		w[DCSW_SB_INHIB]  = (so.state_code == DCSW_STATE_INHIBIT);
		w[DCSW_SB_REMOTE] = remote_sel;
		return w;
	endfunction : status_word

	logic link;
	logic coast_src;
	logic quick_src;
	logic clr_bit;

	always_comb begin
		st_nxt    = st_r;
		link      = st_r.mode[DCSW_MB_LINK];
		clr_bit   = ctrl_word[DCSW_CB_CLEAR];
		coast_src = link ? ctrl_word[DCSW_CB_COAST]
		                 : loc_r.freewheel_off_command;
		quick_src = link ? ctrl_word[DCSW_CB_QUICK]
		                 : loc_r.quick_off_command;

		if (bus.wr && bus.addr == DCSW_ADDR_MODE) begin
			st_nxt.mode = bus.wdata[2:0];
		end

		st_nxt.clr_prev = clr_bit;

		if (link) begin
			st_nxt.seq.forward_run_request =
				ctrl_word[DCSW_CB_RUN];
			st_nxt.seq.reverse_run_request   = 1'b0;
			st_nxt.seq.halt_inhibit          = 1'b0;
			st_nxt.seq.freewheel_off_command =
				ctrl_word[DCSW_CB_COAST];
			st_nxt.seq.quick_off_command =
				ctrl_word[DCSW_CB_QUICK];
			st_nxt.seq.output_permit = ctrl_word[DCSW_CB_PERM];
			// Level held high must not retrigger a fault reset
			st_nxt.seq.remote_fault_clear =
				clr_bit && !st_r.clr_prev;
		end else begin
			st_nxt.seq = loc_r;
		end

		// Read data stand one cycle after the strobe only
		st_nxt.rdata = 16'h0000;
		if (bus.rd) begin
			if (bus.addr == DCSW_ADDR_CTRL) begin
				st_nxt.rdata = ctrl_word;
			end else if (bus.addr == DCSW_ADDR_STATUS) begin
				st_nxt.rdata = status_word(seq_out, link,
					st_r.mode[DCSW_MB_REM] && st_r.mode[DCSW_MB_SEL],
					coast_src, quick_src);
			end else if (bus.addr == DCSW_ADDR_MODE) begin
				st_nxt.rdata = {13'h0000, st_r.mode};
			end else if (bus.addr == DCSW_ADDR_SEQ) begin
				st_nxt.rdata = {9'h000, st_r.seq};
			end else begin
				st_nxt.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= '{mode: DCSW_MODE_RST, clr_prev: 1'b0,
			          seq: '0, rdata: 16'h0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata  = st_r.rdata;
	assign seq_in = st_r.seq;

endmodule : dcsw_top

// *** verification/dcsw_checker.sv ***
`timescale 1ns/100ps
module dcsw_checker (
	// Watched ports
	input wire logic                    clk,
	input wire logic                    arst_n,
	input wire dcsw_pkg::dcsw_bus_s     bus,
	input wire logic             [15:0] rdata,
	input wire dcsw_pkg::dcsw_seq_in_s  local_in,
	input wire dcsw_pkg::dcsw_seq_out_s seq_out,
	input wire dcsw_pkg::dcsw_seq_in_s  seq_in
);
	import dcsw_pkg::*;
	logic [15:0] ctrl_r;
	logic [2:0]  mode_r;
	wire wc = bus.wr && bus.addr == DCSW_ADDR_CTRL;
	wire rs = bus.rd && bus.addr == DCSW_ADDR_STATUS;
	wire [3:0] so4 = {seq_out.fault_latched, seq_out.operating,
		seq_out.stack_energised, seq_out.ready_to_energise};
	function automatic logic [5:0] dec(input logic [15:0] c);
		return {c[0], 2'b00, c[1], c[2], c[3]};
	endfunction : dec
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= '0;
			mode_r <= '0;
		end else begin
			if (wc) ctrl_r <= bus.wdata;
			if (bus.wr && bus.addr == DCSW_ADDR_MODE) mode_r <= bus.wdata[2:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// --
	// Properties
	// --
	property p_diag; bus.rd && bus.addr == 4'h0 |=> rdata == ctrl_r; endproperty
	a_diag: assert property (p_diag) else $error("ctrl readback");
	property p_zero; rs |=> (rdata & 16'hfd80) == 16'h0; endproperty
	a_zero: assert property (p_zero) else $error("reserved set");
	property p_seq; rs |=> rdata[3:0] == $past(so4); endproperty
	a_seq: assert property (p_seq) else $error("seq flags");
	property p_inh; rs |=> rdata[6] == ($past(seq_out.state_code) == 3'h1);
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit bit");
	property p_rem; rs |=> rdata[9] == (mode_r[1] & mode_r[2]); endproperty
	a_rem: assert property (p_rem) else $error("remote bit");
	property p_mir; rs && mode_r[0] |=> rdata[5:4] == ctrl_r[2:1]; endproperty
	a_mir: assert property (p_mir) else $error("mirror bits");
	property p_dec; wc && mode_r[0] |-> ##2 seq_in[6:1] == dec($past(ctrl_r));
	endproperty
	a_dec: assert property (p_dec) else $error("decode");
	property p_rise;
		wc && mode_r[0] && bus.wdata[7] && !ctrl_r[7]
			|-> ##2 seq_in.remote_fault_clear ##1 !seq_in.remote_fault_clear;
	endproperty
	a_rise: assert property (p_rise) else $error("clear pulse");
	property p_lvl; wc && mode_r[0] && ctrl_r[7] |-> ##2 !seq_in.remote_fault_clear;
	endproperty
	a_lvl: assert property (p_lvl) else $error("clear on level");
	c_stat: cover property (rs && mode_r[0]);
	c_rise: cover property (wc && mode_r[0] && bus.wdata[7] && !ctrl_r[7]);
	c_loc: cover property (bus.rd && bus.addr == DCSW_ADDR_SEQ && !mode_r[0]);
endmodule : dcsw_checker
bind dcsw_top dcsw_checker chk (.clk(clk), .arst_n(arst_n), .bus(bus),
	.rdata(rdata), .local_in(local_in), .seq_out(seq_out), .seq_in(seq_in));

// *** verification/dcsw_remote_ctl.sv ***
`timescale 1ns/100ps
module dcsw_remote_ctl (
	// Bus master side
	input wire logic            clk,
	output dcsw_pkg::dcsw_bus_s bus
);
	import dcsw_pkg::*;
	initial bus = '0;
	// --
	// Bus cycles
	// --
	// Idle cycle after each strobe keeps one assignment per time step
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		@(posedge clk);
		bus <= '{a, d, w, !w};
		@(posedge clk);
		bus <= '0;
	endtask : xfer
	task automatic cmd(input logic clr, input logic [3:0] lo);
		xfer(1'b1, DCSW_ADDR_CTRL, {8'h04, clr, 3'h7, lo});
	endtask : cmd
endmodule : dcsw_remote_ctl

// *** verification/test_drive_control_status_word.sv ***
`timescale 1ns/100ps
module test_drive_control_status_word;
	import dcsw_pkg::*;
	logic          clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          pend = 1'b0;
	dcsw_bus_s     bus;
	logic [15:0]   rdata;
	logic [15:0]   w;
	logic [3:0]    lo;
	logic [2:0]    m;
	dcsw_seq_in_s  local_in, seq_in;
	dcsw_seq_out_s seq_out;
	logic [15:0]   exp_q[$];
	int            fails = 0, num_checks = 0, pulses = 0, p0, cyc = 0;
	initial begin
		forever #2.5 clk = ~clk;
	end
	dcsw_remote_ctl ctl (.clk(clk), .bus(bus));
	dcsw_top uut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.local_in(local_in), .seq_out(seq_out), .seq_in(seq_in));
	// --
	// Tasks
	// --
	task automatic bad(input string s);
		fails++;
		$display("unexpected at %0t: %s", $time, s);
	endtask : bad
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		ctl.xfer(1'b0, a, 16'h0);
	endtask : rd
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// Read data stands one cycle only, so compare right at that edge
	always @(posedge clk) begin
		if (pend) begin
			num_checks++;
			if (exp_q.size() == 0 || rdata !== exp_q[0]) bad("rdata");
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
		pend <= bus.rd;
		pulses <= pulses + int'($rose(seq_in.remote_fault_clear));
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			bad("timeout");
			tally_and_finish();
		end
	end
	initial begin
		local_in = '0;
		seq_out = '0;
		void'($urandom(32'h3b57));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(DCSW_ADDR_CTRL, 16'h0);
		rd(4'h2, 16'h0);
		for (int i = 0; i < 24; i++) begin
			m = 3'($urandom);
			lo = 4'($urandom);
			local_in <= 7'($urandom);
			seq_out <= 7'($urandom);
			ctl.xfer(1'b1, DCSW_ADDR_MODE, {13'h0, m});
			ctl.cmd(1'b0, lo);
			ctl.xfer(1'b1, DCSW_ADDR_STATUS, 16'hffff);
			w = {8'h04, 4'h7, lo};
			rd(DCSW_ADDR_CTRL, w);
			rd(DCSW_ADDR_MODE, {13'h0, m});
			rd(DCSW_ADDR_SEQ, {9'h0, m[0] ? {lo[0], 2'b00, lo[1], lo[2],
				lo[3], 1'b0} : local_in});
			rd(DCSW_ADDR_STATUS, {6'h0, m[1] & m[2], 2'h0,
				seq_out.state_code == 3'h1, m[0] ? lo[2:1] :
				{local_in.quick_off_command, local_in.freewheel_off_command},
				seq_out[3], seq_out[4], seq_out[5], seq_out[6]});
		end
		ctl.xfer(1'b1, DCSW_ADDR_MODE, 16'h1);
		p0 = pulses;
		ctl.cmd(1'b1, 4'hf);
		ctl.cmd(1'b1, 4'hf);
		ctl.cmd(1'b0, 4'he);
		ctl.cmd(1'b1, 4'hf);
		repeat (3) @(posedge clk);
		num_checks++;
		if (pulses - p0 != 2) bad("clear count");
		tally_and_finish();
	end
endmodule : test_drive_control_status_word
